// file: core/sldrv_pkg.sv
package sldrv_pkg;
  // number of driver outputs per device
  localparam int unsigned SLDRV_NUM_OUT = 33;
  // latch and shift register contents after reset
  localparam logic [32:0] SLDRV_RST_VAL = 33'h0_0000_0000;
  // synchroniser depth for pins
  localparam int unsigned SLDRV_SYNC_STAGES = 2;
  // state encoding
  typedef enum logic [1:0] {
    SLDRV_ST_POR = 2'b00,
    SLDRV_ST_RUN = 2'b01,
    SLDRV_ST_LDRST = 2'b10
  } sldrv_state_t;
endpackage : sldrv_pkg

// file: core/sldrv_sync.sv
`timescale 1ns/100ps
`default_nettype none
module sldrv_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule : sldrv_sync
`default_nettype wire

// file: core/sldrv_top.sv
`timescale 1ns/100ps
`default_nettype none
module sldrv_top
  import sldrv_pkg::*;
#(
  parameter int unsigned NUM_OUT = sldrv_pkg::SLDRV_NUM_OUT
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // serial link pins
  input wire logic ser_data_in,
  input wire logic ser_clk,
  input wire logic load,
  output logic ser_data_out,
  // LED sink drive, high = on
  output logic [NUM_OUT-1:0] led_on
);
  import sldrv_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  logic [2:0] pin_sync;
  logic sclk_s, data_s, load_s;
  logic sclk_d_reg, load_d_reg;
  logic sclk_rise, load_rise;

  sldrv_sync #(.WIDTH(3)) u_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({ser_clk, ser_data_in, load}),
    .q(pin_sync)
  );
  assign sclk_s = pin_sync[2];
  assign data_s = pin_sync[1];
  assign load_s = pin_sync[0];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
      load_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      load_d_reg <= load_s;
    end
  end
  // shift clock is slow enough (<=0.5 MHz) to find every edge
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign load_rise = load_s & ~load_d_reg;

  // ****************************************
  // reset state
  // ****************************************
  sldrv_state_t state_reg, state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // leading clock ends the reset condition, no data taken
      SLDRV_ST_POR: if (sclk_rise) state_next = SLDRV_ST_RUN;
      SLDRV_ST_RUN: if (load_rise) state_next = SLDRV_ST_LDRST;
      SLDRV_ST_LDRST: if (sclk_rise) state_next = SLDRV_ST_RUN;
      default: state_next = SLDRV_ST_POR;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SLDRV_ST_POR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // shift register, bit 0 is first stage
  // ****************************************
  logic [NUM_OUT-1:0] shift_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= SLDRV_RST_VAL[NUM_OUT-1:0];
    end else if (state_reg != SLDRV_ST_RUN) begin
      shift_reg <= SLDRV_RST_VAL[NUM_OUT-1:0];
    end else if (load_rise) begin
      shift_reg <= SLDRV_RST_VAL[NUM_OUT-1:0];
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[NUM_OUT-2:0], data_s};
    end
  end

  // ****************************************
  // output latches
  // ****************************************
  logic [NUM_OUT-1:0] latch_reg;
  logic [NUM_OUT-1:0] latch_next;
  // first bit in sits at the top stage after a full frame
  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      latch_next[i] = shift_reg[NUM_OUT-1-i];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= SLDRV_RST_VAL[NUM_OUT-1:0];
    end else if (load_rise && state_reg == SLDRV_ST_RUN) begin
      // single register write: equal bits cannot glitch
      latch_reg <= latch_next;
    end
  end
  assign led_on = latch_reg;

  // ****************************************
  // cascade output
  // ****************************************
  logic sdo_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_reg <= 1'b0;
    end else begin
      sdo_reg <= shift_reg[NUM_OUT-1];
    end
  end
  assign ser_data_out = sdo_reg;
endmodule : sldrv_top
`default_nettype wire

// file: testbench/sldrv_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module sldrv_asserts #(
  parameter int unsigned NUM_OUT = 33
) (
  // watched ports
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ser_data_in,
  input wire logic ser_clk,
  input wire logic load,
  input wire logic ser_data_out,
  input wire logic [NUM_OUT-1:0] led_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  led_cause_a: assert property ($changed(led_on) |-> $past(load, 3) || $past(load, 4))
    else $error("led_on moved without load");
  led_hold_a: assert property ((!load) [*8] |-> $stable(led_on))
    else $error("led_on moved while idle");
  por_clear_a: assert property ($rose(rst_b) |-> led_on == '0 && !ser_data_out)
    else $error("not clear after reset");
  ld_clear_a: assert property ($rose(load) |-> ##6 !ser_data_out)
    else $error("shift stages not cleared by load");
  ld_keep_a: assert property ($fell(load) |-> $stable(led_on) [*4])
    else $error("latches lost after load");
  // set once a shift clock has followed the last load, so the next load updates the latches
  logic armed_reg;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_reg <= 1'b0;
    end else if ($rose(load)) begin
      armed_reg <= 1'b0;
    end else if ($rose(ser_clk)) begin
      armed_reg <= 1'b1;
    end
  end
  first_bit_a: assert property ($rose(load) && armed_reg |->
    ##6 led_on[0] == $past(ser_data_out, 6))
    else $error("first bit not on output one");
  sout_cause_a: assert property ($changed(ser_data_out) |->
    $past(ser_clk, 3) || $past(ser_clk, 4) || $past(load, 3) || $past(load, 4))
    else $error("serial out moved without cause");
  sout_still_a: assert property ((!ser_clk && !load) [*8] |-> $stable(ser_data_out))
    else $error("serial out moved while idle");
endmodule : sldrv_asserts
bind sldrv_top sldrv_asserts #(.NUM_OUT(NUM_OUT)) sldrv_asserts_u (.core_clk(core_clk),
  .rst_b(rst_b), .ser_data_in(ser_data_in), .ser_clk(ser_clk), .load(load),
  .ser_data_out(ser_data_out), .led_on(led_on));
`default_nettype wire

// file: testbench/sldrv_src.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// serial data source
// ****
module sldrv_src (
  // clock and pins
  input wire logic core_clk,
  output logic ser_data_in,
  output logic ser_clk,
  output logic load
);
  initial begin
    ser_data_in = 1'b0;
    ser_clk = 1'b0;
    load = 1'b0;
  end
  task automatic tick(input logic d);
    repeat (4) @(negedge core_clk);
    ser_data_in = d;
    repeat (4) @(negedge core_clk);
    ser_clk = 1'b1;
    repeat (8) @(negedge core_clk);
    ser_clk = 1'b0;
  endtask : tick
  task automatic strobe;
    load = 1'b1;
    repeat (8) @(negedge core_clk);
    load = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask : strobe
  task automatic send(input logic [32:0] v);
    tick(~v[0]);
    for (int i = 0; i < 33; i++) tick(v[i]);
    ser_data_in = ~v[32];
    strobe();
  endtask : send
endmodule : sldrv_src
`default_nettype wire

// file: testbench/serial_led_driver_shift_latch_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define SLDRV_CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t mismatch %h vs %h", $time, a, e); end end
// ****
// bench
// ****
module serial_led_driver_shift_latch_bench;
  import sldrv_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ser_data_in, ser_clk, load, ser_data_out;
  logic [32:0] led_on;
  int miscompares = 0;
  int n_tests = 0;
  // frame shifted, equal to the expected led_on
  logic [32:0] rows [4] = '{33'h1_0000_0001, 33'h1_ffff_ffff, 33'h0_0000_0000, 33'h0_5555_5555};
  always #5 core_clk = ~core_clk;
  sldrv_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .ser_data_in(ser_data_in),
    .ser_clk(ser_clk), .load(load), .ser_data_out(ser_data_out), .led_on(led_on));
  sldrv_src src_u (.core_clk(core_clk), .ser_data_in(ser_data_in), .ser_clk(ser_clk),
    .load(load));
  task automatic close_out;
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    `SLDRV_CHK(led_on, SLDRV_RST_VAL)
    foreach (rows[i]) begin
      src_u.send(rows[i]);
      `SLDRV_CHK(led_on, rows[i])
    end
    src_u.strobe();
    `SLDRV_CHK(led_on, rows[3])
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    `SLDRV_CHK({ser_data_out, led_on}, {1'b0, SLDRV_RST_VAL})
    rst_b = 1'b1;
    src_u.send(33'h1_aaaa_aaaa);
    `SLDRV_CHK(led_on, 33'h1_aaaa_aaaa)
    // cascade: one extra bit pushes the first bit out and shifts the frame
    src_u.tick(1'b0);
    for (int i = 0; i < 33; i++) src_u.tick(rows[0][i]);
    `SLDRV_CHK(ser_data_out, rows[0][0])
    src_u.tick(1'b0);
    `SLDRV_CHK(ser_data_out, rows[0][1])
    src_u.strobe();
    `SLDRV_CHK(led_on, 33'h0_8000_0000)
    close_out();
  end
  initial begin
    #100us;
    miscompares++;
    close_out();
  end
endmodule : serial_led_driver_shift_latch_bench
`default_nettype wire
